//--- i2c_bus_peer.sv
`timescale 1ns/10ps
module i2c_bus_peer (
	input  wire scl_w,
	input  wire sda_w,
	output reg  scl_o,
	output reg  sda_o,
	output reg  hung
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		hung = 1'b0;
	end
	// lines are pulled up, so a released line reads high, never stale
	task wt(input v);
		integer n;
		begin
			n = 0;
			while (scl_w !== v && n < 4000) begin
				#5;
				n = n + 1;
			end
			if (scl_w !== v)
				hung = 1'b1;
		end
	endtask
	// sda moves well after the fall so it is never seen as start or stop
	task bit_io(input b, output r);
		begin
			#30;
			sda_o = b;
			#70;
			scl_o = 1'b1;
			wt(1'b1);
			#50;
			r = sda_w;
			#50;
			scl_o = 1'b0;
		end
	endtask
	task start;
		begin
			sda_o = 1'b0;
			#100;
			scl_o = 1'b0;
		end
	endtask
	task stop;
		begin
			#30;
			sda_o = 1'b0;
			#70;
			scl_o = 1'b1;
			wt(1'b1);
			#100;
			sda_o = 1'b1;
			#100;
		end
	endtask
	task xfer(input [7:0] d, input a9, output [8:0] r);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bit_io(d[i], r[i+1]);
			bit_io(a9, r[0]);
		end
	endtask
	task ack_slave(input a, output [7:0] d);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				wt(1'b0);
				wt(1'b1);
				#10;
				d[i] = sda_w;
			end
			wt(1'b0);
			#30;
			sda_o = a;
			wt(1'b1);
			wt(1'b0);
			#30;
			sda_o = 1'b1;
		end
	endtask
endmodule

//--- i2c_stretch_map.vh
// Functional notes
// [RULE1] 10-bit address: stretch on address flag, keep release bit
// [RULE2] address flag set after high byte, then write
// [RULE3] address register write releases stretch, clears flag
// [RULE4] buffer-full stretch only on data, never address
// [RULE5] 7-bit transmit: clear release bit if buffer empty
// [RULE6] buffer loaded before ninth fall: no stretch
// [RULE7] software may set release bit any time
// [RULE8] 10-bit transmit: third header enters transmit, no flag
// [RULE9] drive SCL low only once sampled low
// [RULE10] hold SCL low until release bit set
// [RULE11] general call compares all-zero write address too
// [RULE12] general call loads buffer, full, interrupt
// [RULE13] 10-bit general call skips second byte, no flag
// [RULE14] start and stop seen cleared on reset, disable
// [RULE15] buffer write during start is discarded, collision flag
// [RULE16] master interrupt on start, stop, byte, acknowledge
// [RULE17] master transmit sends address, bytes, receives acknowledge
// [RULE18] master receive clocks bytes, sends acknowledge each
// [RULE19] slave acknowledge captured into status bit, interrupt
// [RULE20] stop enable makes stop, interrupt when done
// [RULE21] generator reloads from low seven address bits
// [RULE22] generator steps twice per instruction cycle
// [RULE23] operation done: counter stops, SCL holds state
// [RULE24] released SCL: wait high, then reload generator
// [RULE25] receive stretch enable holds SCL after data
// [RULE26] header 11110 marks a 10-bit address
// [RULE27] enabled two-wire mode makes pins open-drain
// [RULE28] software clears interrupt and collision flags
`ifndef I2C_STRETCH_MAP_VH
`define I2C_STRETCH_MAP_VH

`define MODE_SL7      4'h6
`define MODE_SL10     4'h7
`define MODE_MASTER   4'h8
`define MODE_SL7_SP   4'he
`define MODE_SL10_SP  4'hf

`define TEN_HDR       5'h1e
`define GC_ADDR       8'h00
`define BYTE_BITS     4'h8
`define ACK_CLOCK     4'h9
`define LAST_TX_BIT   4'h8
`define LAST_RX_BIT   4'h7
`define LAST_ACK_BIT  4'h0
`define BRG_RELOAD_W  7

// system clock period in ns, instruction cycle = 4 system clocks,
// generator steps on the second and fourth quarter of it
`define SYS_CLK_NS    25
`define TCY_CLKS      4
`define PHASE_INIT    2'h0

`define OP_START      3'h0
`define OP_RSTART     3'h1
`define OP_TX         3'h2
`define OP_RX         3'h3
`define OP_ACK        3'h4
`define OP_STOP       3'h5

`endif

//--- i2c_stretch_master_brg.v
`timescale 1ns/10ps
`include "i2c_stretch_map.vh"

module i2c_stretch_master_brg (
	input  wire       sys_clk,
	input  wire       nrst,
	input  wire       port_enable_bit,
	input  wire [3:0] port_mode_select,
	input  wire       general_call_enable,
	input  wire       stretch_or_start_enable,
	input  wire       restart_req,
	input  wire       stop_enable_bit,
	input  wire       rcv_enable_req,
	input  wire       ack_seq_req,
	input  wire       ack_data_bit,
	input  wire       addr_wr,
	input  wire [7:0] addr_wdata,
	input  wire       buf_wr,
	input  wire [7:0] buf_wdata,
	input  wire       buf_rd,
	input  wire       ckp_set,
	input  wire       ckp_clr,
	input  wire       int_clr,
	input  wire       write_collision_flag_clr,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       scl_out,
	output wire       scl_oe_n,
	output wire       sda_out,
	output wire       sda_oe_n,
	output wire [7:0] transfer_buffer,
	output wire [7:0] address_baud_register,
	output wire       buffer_full_flag,
	output wire       address_update_flag,
	output wire       clock_release_bit,
	output wire       port_interrupt_flag,
	output wire       write_collision_flag,
	output wire       ack_status_bit,
	output wire       start_seen,
	output wire       stop_seen,
	output wire       rw_status,
	output wire       master_busy
);

	localparam M_IDLE  = 3'h0;
	localparam M_LO    = 3'h1;
	localparam M_WAITH = 3'h2;
	localparam M_HI    = 3'h3;
	localparam M_FIN   = 3'h4;

	function is_ten;
		input [3:0] m;
		begin
			is_ten = (m == `MODE_SL10) || (m == `MODE_SL10_SP);
		end
	endfunction

	function is_slave;
		input [3:0] m;
		begin
			is_slave = (m == `MODE_SL7) || (m == `MODE_SL10) ||
				(m == `MODE_SL7_SP) || (m == `MODE_SL10_SP);
		end
	endfunction

	reg       scl_m_r, scl_s_r, scl_d_r;
	reg       sda_m_r, sda_s_r, sda_d_r;
	reg [1:0] phase_r;
	reg [6:0] brg_r;
	reg [7:0] buf_r, adr_r, sr_r;
	reg       bf_r, ua_r, ckp_r, int_r, write_collision_flag_r, ackst_r, rw_r;
	reg       start_r, stop_r;
	reg       scl_oe_n_r, sda_oe_n_r;
	reg       sl_act_r, sl_addr_r, sl_acnt_r, sl_tx_r, hi_ok_r;
	reg [3:0] bit_cnt_r;
	reg       ack_drv_r, ev_r, ua_hold_r, scl_hold_r, data_byte_r;
	reg [2:0] m_st_r, m_op_r;
	reg [3:0] m_bit_r;
	reg       m_scl_low_r, m_sda_low_r;

	wire mst      = port_enable_bit && (port_mode_select == `MODE_MASTER);
	wire slv      = port_enable_bit && is_slave(port_mode_select);
	wire ten      = is_ten(port_mode_select);
	wire scl_rise = scl_s_r && !scl_d_r;
	wire scl_fall = !scl_s_r && scl_d_r;
	wire bus_st   = scl_s_r && scl_d_r && !sda_s_r && sda_d_r;
	wire bus_sp   = scl_s_r && scl_d_r && sda_s_r && !sda_d_r;
	// generator steps on odd phases only: two steps per instruction
	wire tick     = phase_r[0]; // see [RULE22]
	wire counting = (m_st_r == M_LO) || (m_st_r == M_HI) ||
		(m_st_r == M_FIN);
	wire expire   = counting && tick && (brg_r == 7'h00);
	wire [6:0] reload = adr_r[`BRG_RELOAD_W-1:0]; // see [RULE21]
	wire gc       = general_call_enable && (sr_r == `GC_ADDR); // see [RULE11]
	wire hdr      = (sr_r[7:3] == `TEN_HDR) &&
		(sr_r[2:1] == adr_r[2:1]); // see [RULE26]
	wire m_last   = (m_op_r == `OP_TX) ? (m_bit_r == `LAST_TX_BIT) :
		(m_op_r == `OP_RX) ? (m_bit_r == `LAST_RX_BIT) :
		(m_bit_r == `LAST_ACK_BIT);
	wire next_low = (m_op_r == `OP_TX) && (m_bit_r < `LAST_RX_BIT) &&
		!sr_r[6];
	wire sl_hold  = sl_act_r && (!ckp_r || ua_hold_r);
	wire tx_drv   = sl_act_r && sl_tx_r && !sl_addr_r &&
		(bit_cnt_r < `BYTE_BITS);

	assign scl_out               = 1'b0;
	assign sda_out               = 1'b0;
	assign scl_oe_n              = scl_oe_n_r;
	assign sda_oe_n              = sda_oe_n_r;
	assign transfer_buffer       = buf_r;
	assign address_baud_register = adr_r;
	assign buffer_full_flag      = bf_r;
	assign address_update_flag   = ua_r;
	assign clock_release_bit     = ckp_r;
	assign port_interrupt_flag   = int_r;
	assign write_collision_flag  = write_collision_flag_r;
	assign ack_status_bit        = ackst_r;
	assign start_seen            = start_r;
	assign stop_seen             = stop_r;
	assign rw_status             = rw_r;
	assign master_busy           = (m_st_r != M_IDLE);

	// the first stage only feeds the second; edges use stages two, three
	always @(posedge sys_clk) begin
		if (!nrst) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
			phase_r <= `PHASE_INIT;
		end else begin
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
			// phase restarts while idle so every operation sees
			// full low phases; costs lock to the instruction phase
			phase_r <= (m_st_r == M_IDLE) ? `PHASE_INIT :
				phase_r + 2'h1;
		end
	end

	// pins only ever pull low; released state floats to the pull-up
	always @(posedge sys_clk) begin
		if (!nrst) begin
			scl_oe_n_r <= 1'b1;
			sda_oe_n_r <= 1'b1;
			scl_hold_r <= 1'b0;
		end else begin
			// stretch joins only a low the other master already made
			scl_hold_r <= slv && sl_hold &&
				(scl_hold_r || !scl_s_r); // see [RULE9]
			// released once the release bit is back and an address write has cleared any address-flag hold; the wire
			// itself stays low while anyone else holds it
			scl_oe_n_r <= !((slv && sl_hold &&
				(scl_hold_r || !scl_s_r)) ||
				(mst && m_scl_low_r)); // see [RULE10] see [RULE27]
			sda_oe_n_r <= !((slv && (ack_drv_r ||
				(tx_drv && !sr_r[7]))) ||
				(mst && m_sda_low_r)); // see [RULE27]
		end
	end

	always @(posedge sys_clk) begin
		if (!nrst) begin
			brg_r       <= 7'h00;
			buf_r       <= 8'h00;
			adr_r       <= 8'h00;
			sr_r        <= 8'h00;
			bf_r        <= 1'b0;
			ua_r        <= 1'b0;
			ckp_r       <= 1'b1;
			int_r       <= 1'b0;
			write_collision_flag_r      <= 1'b0;
			ackst_r     <= 1'b0;
			rw_r        <= 1'b0;
			start_r     <= 1'b0; // see [RULE14]
			stop_r      <= 1'b0;
			sl_act_r    <= 1'b0;
			sl_addr_r   <= 1'b0;
			sl_acnt_r   <= 1'b0;
			sl_tx_r     <= 1'b0;
			hi_ok_r     <= 1'b0;
			bit_cnt_r   <= 4'h0;
			ack_drv_r   <= 1'b0;
			ev_r        <= 1'b0;
			data_byte_r <= 1'b0;
			ua_hold_r   <= 1'b0;
			m_st_r      <= M_IDLE;
			m_op_r      <= `OP_START;
			m_bit_r     <= 4'h0;
			m_scl_low_r <= 1'b0;
			m_sda_low_r <= 1'b0;
		end else begin
			// software side: clears first so that hardware sets win
			if (int_clr)
				int_r <= 1'b0;
			if (write_collision_flag_clr)
				write_collision_flag_r <= 1'b0;
			if (buf_rd)
				bf_r <= 1'b0;
			if (ckp_clr)
				ckp_r <= 1'b0;
			if (addr_wr) begin
				adr_r     <= addr_wdata;
				ua_r      <= 1'b0; // see [RULE3]
				ua_hold_r <= 1'b0;
			end
			if (counting && tick && (brg_r != 7'h00))
				brg_r <= brg_r - 7'h01;

			// bus conditions, seen in every mode
			if (bus_st) begin
				start_r <= 1'b1;
				stop_r  <= 1'b0;
			end
			if (bus_sp) begin
				stop_r  <= 1'b1;
				start_r <= 1'b0;
			end

			// ---------------- slave ----------------
			if (slv && bus_st) begin
				sl_act_r  <= 1'b1;
				sl_addr_r <= 1'b1;
				sl_acnt_r <= 1'b0;
				sl_tx_r   <= 1'b0;
				bit_cnt_r <= 4'h0;
				ack_drv_r <= 1'b0;
				ev_r      <= 1'b0;
			end else if (slv && bus_sp) begin
				sl_act_r  <= 1'b0;
				hi_ok_r   <= 1'b0;
				ack_drv_r <= 1'b0;
			end else if (slv && sl_act_r && scl_rise) begin
				if (bit_cnt_r < `BYTE_BITS) begin
					if (!(sl_tx_r && !sl_addr_r))
						sr_r <= {sr_r[6:0], sda_s_r};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end else if (sl_tx_r && !sl_addr_r && sda_s_r) begin
					// not acknowledged: transfer over, wait for start
					sl_act_r <= 1'b0;
				end
			end else if (slv && sl_act_r && scl_fall) begin
				if (bit_cnt_r == `BYTE_BITS) begin
					bit_cnt_r <= `ACK_CLOCK;
					ev_r      <= 1'b1;
					data_byte_r <= !sl_addr_r; // see [RULE4]
					if (sl_tx_r && !sl_addr_r) begin
						bf_r <= 1'b0;
					end else if (!sl_addr_r || gc) begin
						// data byte, or a general call address
						if (!bf_r) begin
							buf_r     <= sr_r; // see [RULE12]
							bf_r      <= 1'b1;
							ack_drv_r <= 1'b1;
						end
						if (sl_addr_r) begin
							rw_r      <= 1'b0;
							sl_addr_r <= 1'b0; // see [RULE13]
						end
					end else if (!ten) begin
						if (sr_r[7:1] == adr_r[7:1]) begin
							rw_r      <= sr_r[0];
							sl_tx_r   <= sr_r[0];
							sl_addr_r <= 1'b0;
							buf_r     <= sr_r;
							bf_r      <= !sr_r[0] || bf_r;
							ack_drv_r <= !bf_r;
						end else begin
							sl_act_r <= 1'b0;
							ev_r     <= 1'b0;
						end
					end else if (!sl_acnt_r && hdr && sr_r[0] &&
						hi_ok_r) begin
						rw_r      <= 1'b1;
						sl_tx_r   <= 1'b1; // see [RULE8]
						sl_addr_r <= 1'b0;
						buf_r     <= sr_r;
						ack_drv_r <= 1'b1;
					end else if (!sl_acnt_r && hdr && !sr_r[0]) begin
						rw_r      <= 1'b0;
						sl_acnt_r <= 1'b1;
						ua_r      <= 1'b1; // see [RULE2]
						buf_r     <= sr_r;
						bf_r      <= 1'b1;
						ack_drv_r <= !bf_r;
					end else if (sl_acnt_r &&
						(sr_r == adr_r)) begin
						sl_addr_r <= 1'b0;
						hi_ok_r   <= 1'b1;
						ua_r      <= 1'b1; // see [RULE2]
						buf_r     <= sr_r;
						bf_r      <= 1'b1;
						ack_drv_r <= !bf_r;
					end else begin
						sl_act_r <= 1'b0;
						ev_r     <= 1'b0;
					end
				end else if (bit_cnt_r == `ACK_CLOCK) begin
					bit_cnt_r <= 4'h0;
					ack_drv_r <= 1'b0;
					ev_r      <= 1'b0;
					if (ev_r)
						int_r <= 1'b1; // see [RULE12]
					if (ua_r) begin
						// held, but the release bit is left alone
						ua_hold_r <= 1'b1; // see [RULE1]
					end else if (sl_tx_r && !bf_r) begin
						ckp_r <= 1'b0; // see [RULE5] see [RULE6]
					end else if (!sl_tx_r && data_byte_r && ev_r &&
						stretch_or_start_enable && bf_r) begin
						// sl_addr_r drops at the address match, so
						// the byte kind is kept from the eighth fall
						ckp_r <= 1'b0; // see [RULE4] see [RULE25]
					end
				end else if (sl_tx_r && !sl_addr_r &&
					(bit_cnt_r != 4'h0)) begin
					sr_r <= {sr_r[6:0], 1'b0};
				end
			end
			if (slv && buf_wr) begin
				// transmit data also primes the shifter
				buf_r <= buf_wdata;
				sr_r  <= buf_wdata;
				bf_r  <= 1'b1;
			end

			// ---------------- master ----------------
			if (mst && buf_wr) begin
				if (m_st_r != M_IDLE) begin
					// no queueing: write is dropped
					write_collision_flag_r <= 1'b1; // see [RULE15]
				end else begin
					buf_r       <= buf_wdata;
					sr_r        <= buf_wdata;
					bf_r        <= 1'b1;
					m_op_r      <= `OP_TX; // see [RULE17]
					m_bit_r     <= 4'h0;
					m_scl_low_r <= 1'b1;
					m_sda_low_r <= !buf_wdata[7];
					brg_r       <= reload; // see [RULE21]
					m_st_r      <= M_LO;
				end
			end else if (mst && (m_st_r == M_IDLE)) begin
				if (stretch_or_start_enable) begin
					m_op_r      <= `OP_START;
					m_scl_low_r <= 1'b0;
					m_sda_low_r <= 1'b0;
					brg_r       <= reload;
					m_st_r      <= M_HI;
				end else if (restart_req) begin
					m_op_r      <= `OP_RSTART;
					m_scl_low_r <= 1'b1;
					m_sda_low_r <= 1'b0;
					brg_r       <= reload;
					m_st_r      <= M_LO;
				end else if (stop_enable_bit) begin
					m_op_r      <= `OP_STOP; // see [RULE20]
					m_scl_low_r <= 1'b1;
					m_sda_low_r <= 1'b1;
					brg_r       <= reload;
					m_st_r      <= M_LO;
				end else if (rcv_enable_req) begin
					m_op_r      <= `OP_RX; // see [RULE18]
					m_bit_r     <= 4'h0;
					m_scl_low_r <= 1'b1;
					m_sda_low_r <= 1'b0;
					brg_r       <= reload;
					m_st_r      <= M_LO;
				end else if (ack_seq_req) begin
					m_op_r      <= `OP_ACK; // see [RULE18]
					m_bit_r     <= 4'h0;
					m_scl_low_r <= 1'b1;
					m_sda_low_r <= !ack_data_bit;
					brg_r       <= reload;
					m_st_r      <= M_LO;
				end
			end else if (mst) begin
				case (m_st_r)
				M_LO: begin
					if (expire) begin
						m_scl_low_r <= 1'b0;
						m_st_r      <= M_WAITH;
					end
				end
				M_WAITH: begin
					// an outside device may still hold the clock low
					if (scl_s_r) begin
						brg_r  <= reload; // see [RULE24]
						m_st_r <= M_HI;
					end
				end
				M_HI: begin
					if (expire) begin
						brg_r <= reload;
						if ((m_op_r == `OP_START) ||
							(m_op_r == `OP_RSTART)) begin
							m_sda_low_r <= 1'b1;
							m_st_r      <= M_FIN;
						end else if (m_op_r == `OP_STOP) begin
							m_sda_low_r <= 1'b0;
							m_st_r      <= M_FIN;
						end else begin
							m_scl_low_r <= 1'b1;
							if (m_op_r == `OP_RX)
								sr_r <= {sr_r[6:0], sda_s_r};
							else if (m_op_r == `OP_TX)
								sr_r <= {sr_r[6:0], 1'b0};
							if ((m_op_r == `OP_TX) &&
								(m_bit_r == `LAST_RX_BIT)) begin
								bf_r        <= 1'b0;
							end
							if (m_last) begin
								if (m_op_r == `OP_TX)
									ackst_r <= sda_s_r; // see [RULE19]
								if (m_op_r == `OP_RX) begin
									buf_r <= {sr_r[6:0], sda_s_r};
									bf_r  <= 1'b1;
								end
								int_r  <= 1'b1; // see [RULE16]
								// counter idles, SCL stays low
								m_st_r <= M_IDLE; // see [RULE23]
							end else begin
								m_sda_low_r <= next_low;
								m_bit_r     <= m_bit_r + 4'h1;
								m_st_r      <= M_LO;
							end
						end
					end
				end
				M_FIN: begin
					if (expire) begin
						int_r  <= 1'b1; // see [RULE16] see [RULE20]
						m_st_r <= M_IDLE; // see [RULE23]
					end
				end
				default: m_st_r <= M_IDLE;
				endcase
			end

			// software may free the clock whatever the buffer holds
			if (ckp_set)
				ckp_r <= 1'b1; // see [RULE7]
			if (!port_enable_bit) begin
				start_r     <= 1'b0; // see [RULE14]
				stop_r      <= 1'b0;
				sl_act_r    <= 1'b0;
				ack_drv_r   <= 1'b0;
				ua_hold_r   <= 1'b0;
				m_st_r      <= M_IDLE;
				m_scl_low_r <= 1'b0;
				m_sda_low_r <= 1'b0;
			end
		end
	end

endmodule

//--- i2c_stretch_master_brg_properties.sv
`timescale 1ns/10ps
module i2c_stretch_checker (
	input wire       sys_clk,
	input wire       nrst,
	input wire       port_enable_bit,
	input wire [3:0] port_mode_select,
	input wire       stretch_or_start_enable,
	input wire       stop_enable_bit,
	input wire       addr_wr,
	input wire [7:0] addr_wdata,
	input wire       buf_wr,
	input wire       ckp_set,
	input wire       scl_in,
	input wire       sda_in,
	input wire       scl_out,
	input wire       scl_oe_n,
	input wire       sda_out,
	input wire       sda_oe_n,
	input wire [7:0] transfer_buffer,
	input wire [7:0] address_baud_register,
	input wire       address_update_flag,
	input wire       clock_release_bit,
	input wire       port_interrupt_flag,
	input wire       write_collision_flag,
	input wire       start_seen,
	input wire       stop_seen,
	input wire       master_busy
);
	wire mst = port_mode_select == 4'h8;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	// a reload of one gives a low half period of four clocks
	sequence s_pull;
		$fell(scl_oe_n) && mst && address_baud_register[6:0] == 7'h01;
	endsequence
	sequence s_low;
		!scl_oe_n [*3];
	endsequence
	a_brg_low_hold: assert property (s_pull |=> s_low)
		else $error("master scl low phase too short");
	a_pull_when_low: assert property (
		$fell(scl_oe_n) && !mst |-> !$past(scl_in))
		else $error("slave pulled scl while it was high");
	a_stretch_holds: assert property (!scl_oe_n && !clock_release_bit &&
		!ckp_set && !mst && port_enable_bit |=> !scl_oe_n)
		else $error("stretch released without release bit");
	a_ckp_set_any: assert property (ckp_set |=> clock_release_bit)
		else $error("release bit not set by software");
	a_addr_clr_ua: assert property (addr_wr |=> !address_update_flag)
		else $error("address write left update flag set");
	a_addr_load: assert property (
		addr_wr |=> address_baud_register == $past(addr_wdata))
		else $error("address register not loaded");
	a_write_collision_flag_busy: assert property (mst && master_busy && buf_wr |=>
		write_collision_flag && $stable(transfer_buffer))
		else $error("busy buffer write not refused");
	a_seen_clear: assert property (
		!port_enable_bit |=> !start_seen && !stop_seen)
		else $error("start or stop seen kept while disabled");
	a_pins_od: assert property (
		!port_enable_bit |=> scl_oe_n && sda_oe_n && !scl_out && !sda_out)
		else $error("pins not released open drain");
	a_start_int: assert property (mst && stretch_or_start_enable &&
		!master_busy && port_enable_bit && scl_in && sda_in
		|-> ##[1:400] port_interrupt_flag)
		else $error("no interrupt after start");
	a_stop_int: assert property (mst && stop_enable_bit &&
		!master_busy && port_enable_bit |-> ##[1:400] port_interrupt_flag)
		else $error("no interrupt after stop");
endmodule
bind i2c_stretch_master_brg i2c_stretch_checker u_i2c_stretch_checker (.*);

//--- test_i2c_stretch_master_brg.sv
`timescale 1ns/10ps
module test_i2c_stretch_master_brg;
	reg        sys_clk, nrst, port_enable_bit, general_call_enable;
	reg        stretch_or_start_enable;
	reg  [3:0] port_mode_select;
	reg  [7:0] strb, wd, rd8;
	reg  [8:0] rd;
	integer    mismatches, comparisons;
	wire       restart_req = 1'b0;
	wire       rcv_enable_req = 1'b0;
	wire       ack_seq_req = 1'b0;
	wire       ack_data_bit = 1'b0;
	wire       buf_wr = strb[0];
	wire       addr_wr = strb[1];
	wire       buf_rd = strb[2];
	wire       ckp_set = strb[3];
	wire       int_clr = strb[4];
	wire       write_collision_flag_clr = strb[5];
	wire       stop_enable_bit = strb[6];
	wire       ckp_clr = strb[7];
	wire [7:0] addr_wdata = wd;
	wire [7:0] buf_wdata = wd;
	wire       scl_out, scl_oe_n, sda_out, sda_oe_n, peer_scl, peer_sda;
	wire [7:0] transfer_buffer, address_baud_register;
	wire       buffer_full_flag, address_update_flag, clock_release_bit;
	wire       port_interrupt_flag, write_collision_flag, ack_status_bit;
	wire       start_seen, stop_seen, rw_status, master_busy, hung;
	wire       scl_in = scl_oe_n & peer_scl;
	wire       sda_in = sda_oe_n & peer_sda;
	i2c_stretch_master_brg u_i2c_stretch_master_brg (.*);
	i2c_bus_peer u_i2c_bus_peer (.scl_w(scl_in), .sda_w(sda_in),
		.scl_o(peer_scl), .sda_o(peer_sda), .hung(hung));
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;
	task step(input integer n);
		begin
			repeat (n) @(posedge sys_clk);
			#2;
		end
	endtask
	task pulse(input [7:0] m, input [7:0] d);
		begin
			step(1);
			strb = m;
			wd = d;
			step(1);
			strb = 8'h00;
		end
	endtask
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("CHECK FAILED at %0t: got %h exp %h", $time, seen, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, mismatches);
			if (mismatches == 0 && comparisons > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task wait_int;
		integer n;
		begin
			n = 0;
			while (port_interrupt_flag !== 1'b1 && n < 3000) begin
				step(1);
				n = n + 1;
			end
			if (n == 3000) begin
				mismatches = mismatches + 1;
				conclude;
			end
		end
	endtask
	always @(posedge hung) begin
		mismatches = mismatches + 1;
		conclude;
	end
	initial begin
		{strb, wd, port_enable_bit, general_call_enable} = 18'h0;
		{stretch_or_start_enable, nrst, mismatches, comparisons} = 0;
		port_mode_select = 4'h6;
		step(2);
		nrst = 1'b1;
		chk({clock_release_bit, scl_oe_n, sda_oe_n}, 8'h07);
		chk({start_seen, stop_seen, buffer_full_flag}, 8'h00);
		$display("test reset done");
		port_enable_bit = 1'b1;
		stretch_or_start_enable = 1'b1;
		pulse(8'h02, 8'ha0);
		u_i2c_bus_peer.start;
		u_i2c_bus_peer.xfer(8'ha0, 1'b1, rd);
		step(6);
		chk({rd[0], transfer_buffer}, 8'ha0);
		chk({buffer_full_flag, port_interrupt_flag}, 8'h03);
		chk({clock_release_bit, scl_oe_n}, 8'h03);
		pulse(8'h14, 8'h00);
		u_i2c_bus_peer.xfer(8'h5a, 1'b1, rd);
		step(6);
		chk({rd[0], transfer_buffer}, 8'h5a);
		chk({clock_release_bit, scl_oe_n}, 8'h00);
		pulse(8'h08, 8'h00);
		chk({buffer_full_flag, clock_release_bit}, 8'h03);
		step(4);
		chk(scl_oe_n, 8'h01);
		pulse(8'h14, 8'h00);
		u_i2c_bus_peer.stop;
		step(4);
		chk(stop_seen, 8'h01);
		port_enable_bit = 1'b0;
		step(2);
		chk({start_seen, stop_seen}, 8'h00);
		port_enable_bit = 1'b1;
		stretch_or_start_enable = 1'b0;
		$display("test seven bit receive done");
		u_i2c_bus_peer.start;
		u_i2c_bus_peer.xfer(8'ha1, 1'b1, rd);
		step(6);
		chk({rd[0], rw_status, clock_release_bit, scl_oe_n}, 8'h04);
		pulse(8'h01, 8'hc3);
		pulse(8'h18, 8'h00);
		u_i2c_bus_peer.xfer(8'hff, 1'b0, rd);
		chk(rd[8:1], 8'hc3);
		step(6);
		chk({clock_release_bit, scl_oe_n}, 8'h00);
		pulse(8'h18, 8'h00);
		u_i2c_bus_peer.xfer(8'hff, 1'b1, rd);
		u_i2c_bus_peer.stop;
		pulse(8'h14, 8'h00);
		$display("test seven bit transmit done");
		port_mode_select = 4'h7;
		pulse(8'h02, 8'h06);
		u_i2c_bus_peer.start;
		u_i2c_bus_peer.xfer(8'hf6, 1'b1, rd);
		step(6);
		chk({rd[0], address_update_flag, clock_release_bit}, 8'h03);
		chk(scl_oe_n, 8'h00);
		pulse(8'h16, 8'h34);
		step(2);
		chk({address_update_flag, scl_oe_n}, 8'h01);
		u_i2c_bus_peer.xfer(8'h34, 1'b1, rd);
		step(6);
		chk({rd[0], address_update_flag, scl_oe_n}, 8'h02);
		pulse(8'h16, 8'h06);
		u_i2c_bus_peer.stop;
		pulse(8'h14, 8'h00);
		general_call_enable = 1'b1;
		u_i2c_bus_peer.start;
		u_i2c_bus_peer.xfer(8'h00, 1'b1, rd);
		step(6);
		chk({rd[0], transfer_buffer}, 8'h00);
		chk({buffer_full_flag, port_interrupt_flag}, 8'h03);
		chk(address_update_flag, 8'h00);
		u_i2c_bus_peer.stop;
		pulse(8'h14, 8'h00);
		$display("test ten bit and general call done");
		port_mode_select = 4'h8;
		pulse(8'h02, 8'h01);
		stretch_or_start_enable = 1'b1;
		step(1);
		stretch_or_start_enable = 1'b0;
		pulse(8'h01, 8'h77);
		chk({write_collision_flag, transfer_buffer}, 16'h0100);
		wait_int;
		pulse(8'h30, 8'h00);
		fork
			u_i2c_bus_peer.ack_slave(1'b0, rd8);
			pulse(8'h01, 8'ha0);
		join
		wait_int;
		chk(rd8, 8'ha0);
		chk(ack_status_bit, 8'h00);
		pulse(8'h10, 8'h00);
		fork
			u_i2c_bus_peer.ack_slave(1'b1, rd8);
			pulse(8'h01, 8'h3c);
		join
		wait_int;
		chk(rd8, 8'h3c);
		chk(ack_status_bit, 8'h01);
		pulse(8'h10, 8'h00);
		pulse(8'h40, 8'h00);
		wait_int;
		$display("test master done");
		conclude;
	end
endmodule
